// File: rtl/ufmr_pkg.sv
// Constants, types and helpers of the serial frame receiver.
// Assumes a 32-bit APB slave port and one 10 MHz system clock.
package ufmr_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_BAUD = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_ISTAT = 8'h10;
	localparam logic [7:0] OFS_IMASK = 8'h14;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int MODE_INV_BIT = 4;
	localparam int MODE_HS_BIT = 3;
	localparam int MODE_FMT_LSB = 1;
	localparam int MODE_STOP_BIT = 0;
	localparam int ST_WAKE_BIT = 5;
	localparam int ST_IDLE_BIT = 4;
	localparam int ST_PARITY_ERROR_FLAG_BIT = 3;
	localparam int ST_FRAMING_ERROR_FLAG_BIT = 2;
	localparam int ST_OVR_BIT = 1;
	localparam int ST_AVAIL_BIT = 0;
	localparam int IRQ_RXC_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam int IRQ_OVR_BIT = 2;
	localparam int IRQ_WINV_BIT = 3;
	localparam int IRQ_W = 4;
	localparam int BAUD_W = 16;
	// ****************************************
	// Encodings, counts and reset values
	// ****************************************
	localparam logic [1:0] FMT_9N = 2'h3;
	localparam logic [1:0] FMT_8O = 2'h2;
	localparam logic [1:0] FMT_8E = 2'h1;
	localparam logic [1:0] FMT_8N = 2'h0;
	localparam logic [3:0] SMP_LAST_HS = 4'h3;
	localparam logic [3:0] SMP_LAST_STD = 4'hF;
	localparam logic [3:0] SMP_MID_HS = 4'h1;
	localparam logic [3:0] SMP_MID_STD = 4'h7;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_FULL = 3'h4;
	localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;
	localparam logic [IRQ_W-1:0] IMASK_RST = 4'h0;

	typedef struct packed {
		logic inv;
		logic hs;
		logic [1:0] fmt;
		logic stop;
	} ufmr_mode_s;

	typedef struct packed {
		logic parity_error_flag;
		logic framing_error_flag;
		logic [8:0] data;
	} ufmr_char_s;

	typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP} ufmr_rx_e;

	// Data bits per character for a format code
	function automatic logic [3:0] char_bits(input logic [1:0] fmt);
		char_bits = (fmt == FMT_9N) ? BITS_NINE : BITS_EIGHT;
	endfunction : char_bits

	// Format carries a parity bit
	function automatic logic has_parity(input logic [1:0] fmt);
		has_parity = (fmt == FMT_8O) || (fmt == FMT_8E);
	endfunction : has_parity
endpackage : ufmr_pkg

// File: rtl/ufmr_baud.sv
// Baud generator: divides the clock to sampling ticks and marks bit phases.
// Assumes the caller restarts it on every detected start edge.
`timescale 1ns/1ps
module ufmr_baud (
	input wire logic i_clk, // System clock
	input wire logic i_srst, // Sync reset, high
	input wire logic i_ce, // Clock enable
	input wire logic i_restart, // Realign to a start edge
	input wire logic i_hs, // 4 samples per bit when high
	input wire logic [ufmr_pkg::BAUD_W-1:0] i_div, // Cycles per tick minus one
	output logic o_mid, // Pulse at bit centre
	output logic o_end // Pulse at bit end
);
	logic [ufmr_pkg::BAUD_W-1:0] div_reg, div_next;
	logic [3:0] smp_reg, smp_next;
	logic [3:0] seen_reg;
	logic armed_reg, hs_prev_reg;
	logic tick;
	logic [3:0] last;

	// Tick divider and sample counter; restart keeps bits centred on the edge
	always_comb begin
		tick = (div_reg == i_div);
		last = i_hs ? ufmr_pkg::SMP_LAST_HS : ufmr_pkg::SMP_LAST_STD;
		div_next = tick ? '0 : div_reg + 16'h0001;
		smp_next = tick ? ((smp_reg == last) ? 4'h0 : smp_reg + 4'h1) : smp_reg;
		if (i_restart) begin
			div_next = '0;
			smp_next = '0;
		end
		o_mid = tick && !i_restart
			&& (smp_reg == (i_hs ? ufmr_pkg::SMP_MID_HS : ufmr_pkg::SMP_MID_STD));
		o_end = tick && !i_restart && (smp_reg == last);
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			div_reg <= '0;
			smp_reg <= '0;
		end else if (i_ce) begin
			div_reg <= div_next;
			smp_reg <= smp_next;
		end
	end

	// Independent tick tally, only for checking the bit length
	always_ff @(posedge i_clk) begin
		if (i_srst || (i_ce && (i_restart || o_end))) begin
			seen_reg <= 4'h0;
		end else if (i_ce && tick) begin
			seen_reg <= seen_reg + 4'h1;
		end
	end

	// Only bits timed from a start edge are checked; a rate change in idle
	// leaves the free-running counter out of range for one long bit
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			armed_reg <= 1'b0;
			hs_prev_reg <= 1'b0;
		end else if (i_ce) begin
			hs_prev_reg <= i_hs;
			if (i_restart) begin
				armed_reg <= 1'b1;
			end else if (i_hs != hs_prev_reg) begin
				armed_reg <= 1'b0;
			end
		end
	end

	property p_bit_period;
		@(posedge i_clk) disable iff (i_srst || !i_ce)
		(o_end && armed_reg && (i_hs == hs_prev_reg)) |-> (seen_reg == (i_hs ? 4'h3 : 4'hF));
	endproperty
	a_bit_period: assert property (p_bit_period)
		else $error("bit period is not 4 or 16 ticks");
endmodule : ufmr_baud

// File: rtl/ufmr_top.sv
// Serial frame receiver with APB registers, 4-deep character queue, interrupt.
// Assumes an APB master on I_CLK_SYS and an asynchronous receive line pin.
// Summary of operation
// - Polarity bit sets receive line idle level
// - Edge away from idle level starts frame
// - Sampling at 4 or 16 ticks per bit
// - Format field picks width and parity
// - Stop select gives one or two stops
// - First character after wake is discarded
// - Error flags belong to queue head
// - Clearing overrun empties queue and shifter
`timescale 1ns/1ps
module ufmr_top (
	input wire logic I_CLK_SYS, // 10 MHz clock
	input wire logic I_SRST, // Sync reset, high
	input wire logic I_CE, // Freezes all state when low
	input wire logic I_PSEL, // APB select
	input wire logic I_PENABLE, // APB enable
	input wire logic I_PWRITE, // APB direction
	input wire logic [ufmr_pkg::ADDR_W-1:0] I_PADDR, // APB byte address
	input wire logic [31:0] I_PWDATA, // APB write data
	input wire logic I_SERIAL_RECEIVE_LINE, // Receive pin, asynchronous
	input wire logic I_WAKE_EVENT, // Pulse: woke from sleep by line activity
	output logic [31:0] O_PRDATA, // APB read data
	output logic O_PREADY, // APB ready
	output logic O_PSLVERR, // Unmapped address
	output logic O_IRQ // Level interrupt
);
	// ****************************************
	// Declarations
	// ****************************************
	ufmr_pkg::ufmr_mode_s mode_reg, mode_next;
	logic [ufmr_pkg::BAUD_W-1:0] baud_reg, baud_next;
	logic [ufmr_pkg::IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic irq_reg, irq_next;
	logic ovr_reg, ovr_next, wake_reg, wake_next;
	logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
	ufmr_pkg::ufmr_rx_e state_reg, state_next;
	logic [8:0] shift_reg, shift_next;
	logic [3:0] cnt_reg, cnt_next;
	logic parity_error_flag_reg, parity_error_flag_next, framing_error_flag_reg, framing_error_flag_next, stop2_reg, stop2_next;
	ufmr_pkg::ufmr_char_s fifo_reg [ufmr_pkg::FIFO_DEPTH];
	ufmr_pkg::ufmr_char_s fifo_next [ufmr_pkg::FIFO_DEPTH];
	logic [1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [2:0] count_reg, count_next;
	ufmr_pkg::ufmr_char_s entry, head;
	logic rx_lvl, prev_lvl, start_edge, restart, mid, frame_done;
	logic setup, access, wr, rd, mapped, pop, push, overflow, ovr_clear, drop_wake;
	logic [31:0] rd_val;
	logic [ufmr_pkg::IRQ_W-1:0] ev;

	// ****************************************
	// Receive line synchroniser
	// ****************************************
	// Two flops before use; the prev stage feeds only the edge detector
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else if (I_CE) begin
			rx_meta_reg <= I_SERIAL_RECEIVE_LINE;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	// Line normalised so that 1 is idle; a floating pin can still fake a start
	assign rx_lvl = rx_sync_reg ^ mode_reg.inv;
	assign prev_lvl = rx_prev_reg ^ mode_reg.inv;
	assign start_edge = prev_lvl && !rx_lvl;

	ufmr_baud u_baud (
		.i_clk(I_CLK_SYS),
		.i_srst(I_SRST),
		.i_ce(I_CE),
		.i_restart(restart),
		.i_hs(mode_reg.hs),
		.i_div(baud_reg),
		.o_mid(mid),
		.o_end()
	);

	// ****************************************
	// APB decode
	// ****************************************
	// Zero wait states; a low clock enable stretches the access phase
	always_comb begin
		setup = I_PSEL && !I_PENABLE;
		access = I_PSEL && I_PENABLE && I_CE;
		wr = access && I_PWRITE;
		rd = access && !I_PWRITE;
		mapped = (I_PADDR == ufmr_pkg::OFS_MODE) || (I_PADDR == ufmr_pkg::OFS_BAUD)
			|| (I_PADDR == ufmr_pkg::OFS_STAT) || (I_PADDR == ufmr_pkg::OFS_DATA)
			|| (I_PADDR == ufmr_pkg::OFS_ISTAT) || (I_PADDR == ufmr_pkg::OFS_IMASK);
		pop = rd && (I_PADDR == ufmr_pkg::OFS_DATA) && (count_reg != 3'h0);
		ovr_clear = wr && (I_PADDR == ufmr_pkg::OFS_STAT) && ovr_reg
			&& !I_PWDATA[ufmr_pkg::ST_OVR_BIT];
	end
	assign O_PREADY = I_CE;
	assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
	assign O_PRDATA = prdata_reg;
	assign O_IRQ = irq_reg;
	assign head = fifo_reg[rd_reg];

	// Read mux; status flags show the head character, not the newest
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (I_PADDR)
			ufmr_pkg::OFS_MODE: rd_val[4:0] = mode_reg;
			ufmr_pkg::OFS_BAUD: rd_val[ufmr_pkg::BAUD_W-1:0] = baud_reg;
			ufmr_pkg::OFS_STAT: begin
				rd_val[ufmr_pkg::ST_WAKE_BIT] = wake_reg;
				rd_val[ufmr_pkg::ST_IDLE_BIT] = (state_reg == ufmr_pkg::S_IDLE);
				rd_val[ufmr_pkg::ST_PARITY_ERROR_FLAG_BIT] = (count_reg != 3'h0) && head.parity_error_flag;
				rd_val[ufmr_pkg::ST_FRAMING_ERROR_FLAG_BIT] = (count_reg != 3'h0) && head.framing_error_flag;
				rd_val[ufmr_pkg::ST_OVR_BIT] = ovr_reg;
				rd_val[ufmr_pkg::ST_AVAIL_BIT] = (count_reg != 3'h0);
			end
			ufmr_pkg::OFS_DATA: rd_val[8:0] = (count_reg != 3'h0) ? head.data : 9'h000;
			ufmr_pkg::OFS_ISTAT: rd_val[ufmr_pkg::IRQ_W-1:0] = istat_reg;
			ufmr_pkg::OFS_IMASK: rd_val[ufmr_pkg::IRQ_W-1:0] = imask_reg;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Receive state machine
	// ****************************************
	// Samples at bit centre; the baud generator is realigned on each start
	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		parity_error_flag_next = parity_error_flag_reg;
		framing_error_flag_next = framing_error_flag_reg;
		stop2_next = stop2_reg;
		restart = 1'b0;
		frame_done = 1'b0;
		unique case (state_reg)
			ufmr_pkg::S_IDLE: begin
				if (start_edge) begin
					restart = 1'b1;
					parity_error_flag_next = 1'b0;
					framing_error_flag_next = 1'b0;
					state_next = ufmr_pkg::S_START;
				end
			end
			ufmr_pkg::S_START: begin
				cnt_next = 4'h0;
				if (mid) begin
					// Glitch shorter than half a bit is not a start
					state_next = rx_lvl ? ufmr_pkg::S_IDLE : ufmr_pkg::S_DATA;
				end
			end
			ufmr_pkg::S_DATA: begin
				if (mid) begin
					shift_next = {rx_lvl, shift_reg[8:1]};
					cnt_next = cnt_reg + 4'h1;
					if (cnt_next == ufmr_pkg::char_bits(mode_reg.fmt)) begin
						stop2_next = 1'b0;
						state_next = ufmr_pkg::has_parity(mode_reg.fmt)
							? ufmr_pkg::S_PARITY : ufmr_pkg::S_STOP;
					end
				end
			end
			ufmr_pkg::S_PARITY: begin
				if (mid) begin
					// Even: ones plus parity even; odd: ones plus parity odd
					parity_error_flag_next = (^shift_reg[8:1] ^ rx_lvl)
						!= (mode_reg.fmt == ufmr_pkg::FMT_8O);
					state_next = ufmr_pkg::S_STOP;
				end
			end
			ufmr_pkg::S_STOP: begin
				if (mid) begin
					framing_error_flag_next = framing_error_flag_reg || !rx_lvl;
					if (mode_reg.stop && !stop2_reg) begin
						stop2_next = 1'b1;
					end else begin
						frame_done = 1'b1;
						state_next = ufmr_pkg::S_IDLE;
					end
				end
			end
		endcase
		// Overrun clear resets the shifter whatever it was doing
		if (ovr_clear) begin
			state_next = ufmr_pkg::S_IDLE;
			shift_next = 9'h000;
			cnt_next = 4'h0;
			stop2_next = 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			state_reg <= ufmr_pkg::S_IDLE;
			shift_reg <= 9'h000;
			cnt_reg <= 4'h0;
			parity_error_flag_reg <= 1'b0;
			framing_error_flag_reg <= 1'b0;
			stop2_reg <= 1'b0;
		end else if (I_CE) begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			parity_error_flag_reg <= parity_error_flag_next;
			framing_error_flag_reg <= framing_error_flag_next;
			stop2_reg <= stop2_next;
		end
	end

	// ****************************************
	// Character queue, overrun, wake discard
	// ****************************************
	// Eight-bit data sits in the upper bits of the shifter after eight shifts
	always_comb begin
		entry.data = (mode_reg.fmt == ufmr_pkg::FMT_9N) ? shift_reg : {1'b0, shift_reg[8:1]};
		entry.parity_error_flag = parity_error_flag_next;
		entry.framing_error_flag = framing_error_flag_next;
		drop_wake = frame_done && wake_reg;
		push = frame_done && !wake_reg && !ovr_reg && !ovr_clear
			&& ((count_reg != ufmr_pkg::FIFO_FULL) || pop);
		overflow = frame_done && !wake_reg && !ovr_reg && !ovr_clear && !push;
		fifo_next = fifo_reg;
		wr_next = wr_reg;
		rd_next = rd_reg;
		count_next = count_reg;
		if (push) begin
			fifo_next[wr_reg] = entry;
			wr_next = wr_reg + 2'h1;
		end
		if (pop) begin
			rd_next = rd_reg + 2'h1;
		end
		count_next = count_reg + {2'h0, push} - {2'h0, pop};
		if (ovr_clear) begin
			wr_next = 2'h0;
			rd_next = 2'h0;
			count_next = 3'h0;
		end
		// No overflow can occur in the clearing cycle; a frame ending then is dropped and the flag clears
		ovr_next = overflow || (ovr_reg && !ovr_clear);
		wake_next = I_WAKE_EVENT || (wake_reg && !frame_done);
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			wr_reg <= 2'h0;
			rd_reg <= 2'h0;
			count_reg <= 3'h0;
			ovr_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else if (I_CE) begin
			fifo_reg <= fifo_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			count_reg <= count_next;
			ovr_reg <= ovr_next;
			wake_reg <= wake_next;
		end
	end

	// ****************************************
	// Registers and interrupt
	// ****************************************
	// Read snapshot taken in setup; only the reported event bits are cleared,
	// so an event landing between setup and access is kept
	always_comb begin
		ev = '0;
		ev[ufmr_pkg::IRQ_RXC_BIT] = push;
		ev[ufmr_pkg::IRQ_ERR_BIT] = push && (entry.parity_error_flag || entry.framing_error_flag);
		ev[ufmr_pkg::IRQ_OVR_BIT] = overflow;
		ev[ufmr_pkg::IRQ_WINV_BIT] = drop_wake;
		mode_next = mode_reg;
		baud_next = baud_reg;
		imask_next = imask_reg;
		istat_next = istat_reg;
		prdata_next = setup ? rd_val : prdata_reg;
		if (wr && (I_PADDR == ufmr_pkg::OFS_MODE)) begin
			mode_next.inv = I_PWDATA[ufmr_pkg::MODE_INV_BIT];
			mode_next.hs = I_PWDATA[ufmr_pkg::MODE_HS_BIT];
			mode_next.fmt = I_PWDATA[ufmr_pkg::MODE_FMT_LSB +: 2];
			mode_next.stop = I_PWDATA[ufmr_pkg::MODE_STOP_BIT];
		end
		if (wr && (I_PADDR == ufmr_pkg::OFS_BAUD)) begin
			baud_next = I_PWDATA[ufmr_pkg::BAUD_W-1:0];
		end
		if (wr && (I_PADDR == ufmr_pkg::OFS_IMASK)) begin
			imask_next = I_PWDATA[ufmr_pkg::IRQ_W-1:0];
		end
		if (rd && (I_PADDR == ufmr_pkg::OFS_ISTAT)) begin
			istat_next = istat_reg & ~prdata_reg[ufmr_pkg::IRQ_W-1:0];
		end
		istat_next = istat_next | ev;
		irq_next = |(istat_next & imask_next);
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			mode_reg <= '0;
			baud_reg <= ufmr_pkg::BAUD_RST;
			imask_reg <= ufmr_pkg::IMASK_RST;
			istat_reg <= '0;
			prdata_reg <= 32'h0000_0000;
			irq_reg <= 1'b0;
		end else if (I_CE) begin
			mode_reg <= mode_next;
			baud_reg <= baud_next;
			imask_reg <= imask_next;
			istat_reg <= istat_next;
			prdata_reg <= prdata_next;
			irq_reg <= irq_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SRST || !I_CE);

	sequence s_first_stop;
		state_reg == ufmr_pkg::S_STOP && mid && !stop2_reg && mode_reg.stop && !ovr_clear;
	endsequence
	sequence s_enter_stop_again;
		state_reg == ufmr_pkg::S_STOP && stop2_reg;
	endsequence

	property p_idle_level;
		(state_reg == ufmr_pkg::S_IDLE && !ovr_clear && rx_prev_reg != mode_reg.inv
			&& rx_sync_reg == mode_reg.inv) |=> state_reg == ufmr_pkg::S_START;
	endproperty
	a_idle_level: assert property (p_idle_level)
		else $error("edge away from idle level did not start a frame");

	property p_false_start;
		(state_reg == ufmr_pkg::S_START && mid && rx_lvl && !ovr_clear)
			|=> state_reg == ufmr_pkg::S_IDLE;
	endproperty
	a_false_start: assert property (p_false_start)
		else $error("idle level at start centre did not abort");

	property p_parity_fmt;
		state_reg == ufmr_pkg::S_PARITY |-> ufmr_pkg::has_parity(mode_reg.fmt);
	endproperty
	a_parity_fmt: assert property (p_parity_fmt)
		else $error("parity state in a format without parity");

	property p_ninth_bit;
		(state_reg == ufmr_pkg::S_DATA && mid && cnt_reg == 4'h8)
			|-> mode_reg.fmt == ufmr_pkg::FMT_9N;
	endproperty
	a_ninth_bit: assert property (p_ninth_bit)
		else $error("ninth data bit in an eight-bit format");

	property p_two_stop;
		s_first_stop |=> s_enter_stop_again;
	endproperty
	a_two_stop: assert property (p_two_stop)
		else $error("second stop bit not sampled");

	property p_wake_drop;
		(drop_wake && !pop && !ovr_clear && !I_WAKE_EVENT)
			|=> count_reg == $past(count_reg) && !wake_reg;
	endproperty
	a_wake_drop: assert property (p_wake_drop)
		else $error("character after wake was queued");

	property p_head_flags;
		(setup && I_PADDR == ufmr_pkg::OFS_STAT && count_reg != 3'h0)
			|=> O_PRDATA[ufmr_pkg::ST_PARITY_ERROR_FLAG_BIT] == $past(head.parity_error_flag)
			&& O_PRDATA[ufmr_pkg::ST_FRAMING_ERROR_FLAG_BIT] == $past(head.framing_error_flag);
	endproperty
	a_head_flags: assert property (p_head_flags)
		else $error("error flags do not follow the queue head");

	property p_ovr_flush;
		(ovr_clear && !overflow)
			|=> count_reg == 3'h0 && state_reg == ufmr_pkg::S_IDLE && !ovr_reg;
	endproperty
	a_ovr_flush: assert property (p_ovr_flush)
		else $error("overrun clear did not empty the receiver");

	property p_lsb_first;
		(state_reg == ufmr_pkg::S_DATA && mid && !ovr_clear) |=> shift_reg[8] == $past(rx_lvl);
	endproperty
	a_lsb_first: assert property (p_lsb_first)
		else $error("data bit not shifted in at the top");
endmodule : ufmr_top

// File: sim/ufmr_line_model.sv
// Remote serial node: drives whole frames onto the receive line.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module ufmr_line_model (
	input wire logic i_clk, // System clock
	output logic o_line // Receive line into the block
);
	// ****************************************
	// Line driver
	// ****************************************
	logic inv = 1'h0;
	initial o_line = 1'h1; // Pull-up level for default polarity

	// One normalised level held for one bit period
	task automatic put(input logic lvl, input int per);
		o_line <= lvl ^ inv;
		repeat (per) @(posedge i_clk);
	endtask : put

	// Pull follows polarity, so a released line never looks like a start
	task automatic idle(input logic pol);
		@(posedge i_clk);
		inv = pol;
		o_line <= ~pol;
	endtask : idle

	// Start, data LSB first, optional parity, stops; faults only on request
	task automatic send(input logic [8:0] d, input ufmr_pkg::ufmr_mode_s m, input int div,
		input logic bad_par, input logic bad_stop);
		int per;
		logic par;
		per = (div + 1) * (m.hs ? 4 : 16);
		par = (^d[7:0]) ^ m.fmt[1] ^ bad_par;
		@(posedge i_clk);
		put(1'h0, per);
		for (int i = 0; i < ((m.fmt == 2'h3) ? 9 : 8); i++) put(d[i], per);
		if (m.fmt[1] != m.fmt[0]) put(par, per);
		put(~bad_stop, per);
		if (m.stop) put(1'h1, per);
		o_line <= ~inv;
	endtask : send
endmodule : ufmr_line_model

// File: sim/tb_top.sv
// Self-checking bench of the serial frame receiver.
// Assumes the line model beside it and the register map of the package.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'h0;
	logic srst = 1'h1;
	logic ce = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic wake = 1'h0;
	logic line;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [8:0] d;
	logic [31:0] seed = 32'h6258;
	ufmr_pkg::ufmr_mode_s m;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] exp_q[$];
	string name_q[$];

	initial forever #50 clk = ~clk;

	ufmr_top dut_u (.I_CLK_SYS(clk), .I_SRST(srst), .I_CE(ce), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_SERIAL_RECEIVE_LINE(line), .I_WAKE_EVENT(wake), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq));
	ufmr_line_model model_u (.i_clk(clk), .o_line(line));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : compare

	task automatic stop_test();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// Request held from setup until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		// No wait-state count assumed; only the watchdog ends a hung access
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		exp_q.push_back(e);
		name_q.push_back(nm);
		apb(1'h0, a, 32'h0);
	endtask : rd

	// Irq pin looked at mid-cycle, after the register edge
	task automatic chk_irq(input logic e);
		@(negedge clk);
		@(negedge clk);
		compare("irq", {31'h0, e}, {31'h0, irq});
	endtask : chk_irq

	// Polarity moves first at standard rate so the line change starts no frame
	task automatic set_mode(input ufmr_pkg::ufmr_mode_s nm);
		m = nm;
		apb(1'h1, ufmr_pkg::OFS_MODE, {27'h0, m.inv, 4'h0});
		model_u.idle(m.inv);
		repeat (60) @(posedge clk);
		apb(1'h1, ufmr_pkg::OFS_MODE, {27'h0, m});
	endtask : set_mode

	// Each completed read transfer takes the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'h1) begin
			compare("slverr", {31'h0, paddr > 8'h14}, {31'h0, pslverr});
			if (!pwrite && exp_q.size() > 0) begin
				compare(name_q.pop_front(), exp_q.pop_front(), prdata);
			end
		end
	end

	initial begin
		#(60000 * 100);
		failures++;
		stop_test();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'h0;
		rd(ufmr_pkg::OFS_MODE, 32'h0, "mode");
		rd(ufmr_pkg::OFS_STAT, 32'h10, "status");
		rd(ufmr_pkg::OFS_IMASK, 32'h0, "imask");
		rd(8'h18, 32'h0, "unmapped");
		chk_irq(1'h0);
		$display("Test reset done");
		apb(1'h1, ufmr_pkg::OFS_BAUD, 32'h1);
		apb(1'h1, ufmr_pkg::OFS_IMASK, 32'h1);
		for (int k = 0; k < 8; k++) begin
			set_mode({k[1] ^ k[2], k[2] ^ k[0], k[1:0], k[2]});
			seed = lfsr(seed);
			d = (m.fmt == 2'h3) ? seed[8:0] : {1'h0, seed[7:0]};
			model_u.send(d, m, 1, 1'h0, 1'h0);
			rd(ufmr_pkg::OFS_STAT, 32'h11, "status");
			chk_irq(1'h1);
			rd(ufmr_pkg::OFS_ISTAT, 32'h1, "istat");
			chk_irq(1'h0);
			rd(ufmr_pkg::OFS_DATA, {23'h0, d}, "data");
		end
		$display("Test formats done");
		set_mode(5'h02);
		model_u.send(9'h0A5, m, 1, 1'h1, 1'h0);
		model_u.send(9'h03C, m, 1, 1'h0, 1'h0);
		rd(ufmr_pkg::OFS_STAT, 32'h19, "status");
		rd(ufmr_pkg::OFS_ISTAT, 32'h3, "istat");
		rd(ufmr_pkg::OFS_DATA, 32'hA5, "data");
		rd(ufmr_pkg::OFS_STAT, 32'h11, "status");
		rd(ufmr_pkg::OFS_DATA, 32'h3C, "data");
		model_u.send(9'h055, m, 1, 1'h0, 1'h1);
		repeat (40) @(posedge clk);
		rd(ufmr_pkg::OFS_STAT, 32'h15, "status");
		rd(ufmr_pkg::OFS_ISTAT, 32'h3, "istat");
		rd(ufmr_pkg::OFS_DATA, 32'h55, "data");
		$display("Test errors done");
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			model_u.send({1'h0, seed[7:0]}, m, 1, 1'h0, 1'h0);
		end
		rd(ufmr_pkg::OFS_STAT, 32'h13, "status");
		rd(ufmr_pkg::OFS_ISTAT, 32'h5, "istat");
		apb(1'h1, ufmr_pkg::OFS_STAT, 32'h0);
		rd(ufmr_pkg::OFS_STAT, 32'h10, "status");
		rd(ufmr_pkg::OFS_DATA, 32'h0, "data");
		$display("Test overrun done");
		@(posedge clk);
		wake <= 1'h1;
		@(posedge clk);
		wake <= 1'h0;
		rd(ufmr_pkg::OFS_STAT, 32'h30, "status");
		model_u.send(9'h0C3, m, 1, 1'h0, 1'h0);
		rd(ufmr_pkg::OFS_STAT, 32'h10, "status");
		rd(ufmr_pkg::OFS_ISTAT, 32'h8, "istat");
		model_u.send(9'h081, m, 1, 1'h0, 1'h0);
		// Clock enable low in the access phase must stretch it, not lose the pop
		fork
			rd(ufmr_pkg::OFS_DATA, 32'h81, "data");
			begin
				repeat (2) @(posedge clk);
				ce <= 1'h0;
				repeat (3) @(posedge clk);
				ce <= 1'h1;
			end
		join
		rd(ufmr_pkg::OFS_STAT, 32'h10, "status");
		$display("Test wake done");
		stop_test();
	end
endmodule : tb_top
